// *** switch_driver_pkg.sv ***
// Shared constants for the switch driver control block and its controller
package switch_driver_pkg;
  // Register addresses on the serial register link (4-bit address)
  localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_HIGH_SIDE    = 4'h7;
  localparam logic [3:0] ADDR_LOW_SIDE     = 4'h8;
  localparam logic [3:0] ADDR_IRQ          = 4'hD;
  // Control register fields: [0] enable 1, [1] enable 2, [2] gate 1, [3] gate 2
  localparam int EN1_BIT   = 0;
  localparam int EN2_BIT   = 1;
  localparam int GATE1_BIT = 2;
  localparam int GATE2_BIT = 3;
  // Status fields: [0] open load 1, [1] open load 2, [2] limit 1, [3] limit 2
  localparam int OL1_BIT = 0;
  localparam int OL2_BIT = 1;
  localparam int CL1_BIT = 2;
  localparam int CL2_BIT = 3;
  // Mode control fields
  localparam int HV_SHUTDOWN_EN_BIT = 3;
  localparam int MODE_HI_BIT        = 1;
  localparam int MODE_LO_BIT        = 0;
  // Mode encoding
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  // Interrupt source and mask fields
  localparam int HS_IRQ_BIT = 1;
  localparam int LS_IRQ_BIT = 0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Controller register map: byte offsets on the software port
  localparam logic [3:0] OFS_CMD    = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA   = 4'h8;
  localparam logic [3:0] OFS_IRQ    = 4'hC;
  localparam int CMD_WRITE_BIT = 8;
  localparam int BUSY_BIT      = 4;
endpackage

// *** switch_link_if.sv ***
// Interface joining the switch driver block and its controller
`timescale 1ns/100ps
`default_nettype none
interface switch_link_if;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic       modulation_input_pin;
  logic       irq_n;
  logic       reset_pin_n;
  modport device (
    input  wr, rd, addr, wdata, modulation_input_pin, reset_pin_n,
    output rdata, irq_n
  );
  modport host (
    output wr, rd, addr, wdata, modulation_input_pin, reset_pin_n,
    input  rdata, irq_n
  );
endinterface
`default_nettype wire

// *** switch_driver_control.sv ***
// Device end: high and low side switch control, protection and interrupt
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module switch_driver_control (
  // Clock, reset, enable
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  // Link to controller
  switch_link_if.device link,
  // Analog sense inputs, bit 0 is output 1
  input  wire logic [1:0] hs_open_load_i,
  input  wire logic [1:0] hs_current_limit_i,
  input  wire logic       hs_over_temp_i,
  input  wire logic [1:0] ls_open_load_i,
  input  wire logic [1:0] ls_current_limit_i,
  input  wire logic       ls_over_temp_i,
  input  wire logic       supply_high_voltage_i,
  // Switch drives
  output logic            high_side_out_1_o,
  output logic            high_side_out_2_o,
  output logic            low_side_out_1_o,
  output logic            low_side_out_2_o
);
  logic [3:0] high_side_control_reg_r;
  logic [3:0] low_side_control_reg_r;
  logic [3:0] mode_control_reg_r;
  logic [3:0] interrupt_mask_reg_r;
  logic [1:0] interrupt_source_reg_r;
  logic       hs_shutdown_r;
  logic       ls_shutdown_r;
  logic       irq_pending_r;
  logic [3:0] rdata_r;
  logic [1:0] hs_drive;
  logic [1:0] ls_drive;
  logic [3:0] hs_status;
  logic [3:0] ls_status;
  logic       wr_hs;
  logic       wr_ls;
  logic       hv_trip;
  logic       low_power;
  logic [1:0] irq_event;
  logic [1:0] irq_enabled;
  logic       hs_hot_d_r;
  logic       ls_hot_d_r;

  assign wr_hs = link.wr && (link.addr == switch_driver_pkg::ADDR_HIGH_SIDE);
  assign wr_ls = link.wr && (link.addr == switch_driver_pkg::ADDR_LOW_SIDE);
  assign hv_trip = mode_control_reg_r[switch_driver_pkg::HV_SHUTDOWN_EN_BIT]
                   && supply_high_voltage_i;
  assign low_power = mode_control_reg_r[switch_driver_pkg::MODE_HI_BIT:
                                        switch_driver_pkg::MODE_LO_BIT]
                     != switch_driver_pkg::MODE_NORMAL;

  // Per-output drive: enable, optionally gated by the modulation pin
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_drive
      assign hs_drive[g] = high_side_control_reg_r[switch_driver_pkg::EN1_BIT + g]
                           && (!high_side_control_reg_r[switch_driver_pkg::GATE1_BIT + g]
                               || link.modulation_input_pin);
      assign ls_drive[g] = low_side_control_reg_r[switch_driver_pkg::EN1_BIT + g]
                           && (!low_side_control_reg_r[switch_driver_pkg::GATE1_BIT + g]
                               || link.modulation_input_pin);
    end
  endgenerate

  // Control registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      high_side_control_reg_r <= switch_driver_pkg::CTRL_RESET;
      low_side_control_reg_r  <= switch_driver_pkg::CTRL_RESET;
      mode_control_reg_r      <= switch_driver_pkg::CTRL_RESET;
      interrupt_mask_reg_r    <= switch_driver_pkg::MASK_RESET;
    end else if (clk_en_i && link.wr) begin
      case (link.addr)
        switch_driver_pkg::ADDR_HIGH_SIDE:    high_side_control_reg_r <= link.wdata;
        switch_driver_pkg::ADDR_LOW_SIDE:     low_side_control_reg_r  <= link.wdata;
        switch_driver_pkg::ADDR_MODE_CONTROL: mode_control_reg_r      <= link.wdata;
        switch_driver_pkg::ADDR_IRQ:          interrupt_mask_reg_r    <= link.wdata;
        default: ;
      endcase
    end
  end

  // Shutdown latches; a write only re-enables once the fault is gone
  // A write while the fault persists still stores its bits but re-enables nothing
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hs_shutdown_r <= 1'b0;
      ls_shutdown_r <= 1'b0;
    end else if (clk_en_i) begin
      if (hs_over_temp_i || hv_trip) begin
        hs_shutdown_r <= 1'b1;
      end else if (wr_hs) begin
        hs_shutdown_r <= 1'b0;
      end
      if (ls_over_temp_i || hv_trip) begin
        ls_shutdown_r <= 1'b1;
      end else if (wr_ls) begin
        ls_shutdown_r <= 1'b0;
      end
    end
  end

  // High sides are not gated by mode so they may run cyclic sense in low power
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      high_side_out_1_o <= 1'b0;
      high_side_out_2_o <= 1'b0;
      low_side_out_1_o  <= 1'b0;
      low_side_out_2_o  <= 1'b0;
    end else if (clk_en_i) begin
      high_side_out_1_o <= hs_drive[0] && !hs_shutdown_r && !hs_over_temp_i && !hv_trip;
      high_side_out_2_o <= hs_drive[1] && !hs_shutdown_r && !hs_over_temp_i && !hv_trip;
      low_side_out_1_o  <= ls_drive[0] && !ls_shutdown_r && !ls_over_temp_i && !hv_trip
                           && !low_power;
      low_side_out_2_o  <= ls_drive[1] && !ls_shutdown_r && !ls_over_temp_i && !hv_trip
                           && !low_power;
    end
  end

  // High side thermal shutdown shows as every high side flag set; low side flags are not overridden
  // Flags are live levels, not sticky; software samples them by reading
  assign hs_status = hs_shutdown_r && hs_over_temp_i ? 4'hF :
                     {hs_current_limit_i, hs_open_load_i};
  assign ls_status = {ls_current_limit_i, ls_open_load_i};

  // Last cycle's overheat levels; an event is the first hot cycle, so an
  // overheat that starts under a high voltage latch is still reported
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hs_hot_d_r <= 1'b0;
      ls_hot_d_r <= 1'b0;
    end else if (clk_en_i) begin
      hs_hot_d_r <= hs_over_temp_i;
      ls_hot_d_r <= ls_over_temp_i;
    end
  end

  // New events; reset pin low blocks interrupts
  assign irq_event[switch_driver_pkg::HS_IRQ_BIT] = hs_over_temp_i && !hs_hot_d_r;
  assign irq_event[switch_driver_pkg::LS_IRQ_BIT] = ls_over_temp_i && !ls_hot_d_r;
  assign irq_enabled[switch_driver_pkg::HS_IRQ_BIT] =
           interrupt_mask_reg_r[switch_driver_pkg::HS_IRQ_BIT];
  assign irq_enabled[switch_driver_pkg::LS_IRQ_BIT] =
           interrupt_mask_reg_r[switch_driver_pkg::LS_IRQ_BIT];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      interrupt_source_reg_r <= 2'h0;
      irq_pending_r          <= 1'b0;
    end else if (clk_en_i) begin
      // Set wins over the acknowledging read
      if (link.rd && link.addr == switch_driver_pkg::ADDR_IRQ) begin
        interrupt_source_reg_r <= irq_event;
        irq_pending_r          <= 1'b0;
      end else begin
        interrupt_source_reg_r <= interrupt_source_reg_r | irq_event;
      end
      if (link.reset_pin_n && |(irq_event & irq_enabled)) begin
        irq_pending_r <= 1'b1;
      end
    end
  end

  assign link.irq_n = !irq_pending_r;

  // Read data one cycle after the read strobe
  // Unmapped and write-only addresses read as zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_r <= 4'h0;
    end else if (clk_en_i && link.rd) begin
      case (link.addr)
        switch_driver_pkg::ADDR_HIGH_SIDE: rdata_r <= hs_status;
        switch_driver_pkg::ADDR_LOW_SIDE:  rdata_r <= ls_status;
        switch_driver_pkg::ADDR_IRQ:       rdata_r <= {2'h0, interrupt_source_reg_r};
        default:                           rdata_r <= 4'h0;
      endcase
    end
  end
  assign link.rdata = rdata_r;
endmodule
`default_nettype wire

// *** switch_driver_host.sv ***
// Controller end: software command port driving the serial register link
`timescale 1ns/100ps
`default_nettype none
module switch_driver_host (
  // Clock, reset, enable
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  // Software register port
  input  wire logic [3:0] sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic [31:0]     sw_rdata_o,
  // Pins under host control
  input  wire logic       modulation_i,
  input  wire logic       reset_pin_n_i,
  output logic            irq_o,
  // Link to device
  switch_link_if.host     link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_WAIT = 3'b100
  } state_t;
  state_t     state_r;
  logic [8:0] cmd_r;
  logic [3:0] data_r;
  logic       wr_r;
  logic       rd_r;
  logic [3:0] addr_r;
  logic [3:0] wdata_r;
  logic       go;

  // Command word: [3:0] address, [7:4] data, [8] write (else read)
  assign go = sw_wr_i && sw_addr_i == switch_driver_pkg::OFS_CMD && state_r == ST_IDLE;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      cmd_r   <= 9'h000;
      data_r  <= 4'h0;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 4'h0;
      wdata_r <= 4'h0;
    end else if (clk_en_i) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go) begin
            cmd_r   <= sw_wdata_i[8:0];
            state_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          addr_r  <= cmd_r[3:0];
          wdata_r <= cmd_r[7:4];
          wr_r    <= cmd_r[switch_driver_pkg::CMD_WRITE_BIT];
          rd_r    <= !cmd_r[switch_driver_pkg::CMD_WRITE_BIT];
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (rd_r) begin
            state_r <= ST_WAIT;
          end else begin
            data_r  <= link.rdata;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign link.wr    = wr_r;
  assign link.rd    = rd_r;
  assign link.addr  = addr_r;
  assign link.wdata = wdata_r;
  assign link.modulation_input_pin = modulation_i;
  assign link.reset_pin_n = reset_pin_n_i;
  assign irq_o = !link.irq_n;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sw_rdata_o <= 32'h0000_0000;
    end else if (clk_en_i && sw_rd_i) begin
      case (sw_addr_i)
        switch_driver_pkg::OFS_CMD:    sw_rdata_o <= {23'h0, cmd_r};
        switch_driver_pkg::OFS_STATUS: sw_rdata_o <= {27'h0, state_r != ST_IDLE, 4'h0};
        switch_driver_pkg::OFS_DATA:   sw_rdata_o <= {28'h0, data_r};
        switch_driver_pkg::OFS_IRQ:    sw_rdata_o <= {31'h0, !link.irq_n};
        default:                       sw_rdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** switch_driver_assertions.sv ***
// Concurrent checks on the switch link and the switch drives
`timescale 1ns/100ps
`default_nettype none
module switch_driver_assertions (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // Link
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [3:0] addr,
  input wire logic [3:0] wdata,
  input wire logic [3:0] rdata,
  input wire logic       modulation_input_pin,
  input wire logic       irq_n,
  input wire logic       reset_pin_n,
  // Device pins
  input wire logic       hs_over_temp_i,
  input wire logic       ls_over_temp_i,
  input wire logic       supply_high_voltage_i,
  input wire logic       high_side_out_1_o,
  input wire logic       high_side_out_2_o,
  input wire logic       low_side_out_1_o,
  input wire logic       low_side_out_2_o
);
  // Shadows of the written registers, updated on the same edge as the device
  logic [3:0] mode_r, hs_r, ls_r, mask_r;
  logic       hs_wr, ls_wr, md_wr;
  assign hs_wr = wr && addr == switch_driver_pkg::ADDR_HIGH_SIDE;
  assign ls_wr = wr && addr == switch_driver_pkg::ADDR_LOW_SIDE;
  assign md_wr = wr && addr == switch_driver_pkg::ADDR_MODE_CONTROL;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mode_r <= 4'h0;
      hs_r   <= 4'h0;
      ls_r   <= 4'h0;
      mask_r <= 4'h0;
    end else begin
      if (md_wr) mode_r <= wdata;
      if (hs_wr) hs_r <= wdata;
      if (ls_wr) ls_r <= wdata;
      if (wr && addr == switch_driver_pkg::ADDR_IRQ) mask_r <= wdata;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence hot_s;
    hs_over_temp_i [*2];
  endsequence
  sequence status_rd_s;
    rd && addr == switch_driver_pkg::ADDR_HIGH_SIDE;
  endsequence
  hs_trip_a : assert property (
    hs_over_temp_i |=> !high_side_out_1_o && !high_side_out_2_o)
    else $error("high side on in over temperature");
  ls_trip_a : assert property (
    ls_over_temp_i |=> !low_side_out_1_o && !low_side_out_2_o)
    else $error("low side on in over temperature");
  hv_off_a : assert property (
    mode_r[switch_driver_pkg::HV_SHUTDOWN_EN_BIT] && supply_high_voltage_i
    |=> !(high_side_out_1_o || high_side_out_2_o || low_side_out_1_o || low_side_out_2_o))
    else $error("output on in high voltage");
  low_power_a : assert property (
    mode_r[1:0] != switch_driver_pkg::MODE_NORMAL && !md_wr
    |=> !low_side_out_1_o && !low_side_out_2_o)
    else $error("low side on in low power");
  hs_gate_a : assert property (
    hs_r[0] && hs_r[2] && !modulation_input_pin && !hs_wr |=> !high_side_out_1_o)
    else $error("gated high side on with pin low");
  ls_gate_a : assert property (
    ls_r[1] && ls_r[3] && !modulation_input_pin && !ls_wr |=> !low_side_out_2_o)
    else $error("gated low side on with pin low");
  hs_flags_a : assert property (
    hot_s ##0 status_rd_s |=> rdata == 4'hF)
    else $error("flags not all set in shutdown");
  irq_cause_a : assert property (
    $fell(irq_n) |-> $past(reset_pin_n)
      && ($past(hs_over_temp_i && mask_r[switch_driver_pkg::HS_IRQ_BIT])
          || $past(ls_over_temp_i && mask_r[switch_driver_pkg::LS_IRQ_BIT])))
    else $error("unmasked or blocked interrupt raised");
  hs_off_a : assert property (
    !hs_r[switch_driver_pkg::EN2_BIT] |=> !high_side_out_2_o)
    else $error("high side on with enable clear");
  irq_hold_a : assert property (
    !irq_n && !(rd && addr == switch_driver_pkg::ADDR_IRQ) |=> !irq_n)
    else $error("interrupt released without read");
endmodule
`default_nettype wire

// *** switch_driver_control_tb.sv ***
// Self-checking bench joining the controller and the switch block
`timescale 1ns/100ps
`default_nettype none
module switch_driver_control_tb;
  logic        clk_sys_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic [3:0]  sw_addr_i = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic        sw_wr_i = 1'h0, sw_rd_i = 1'h0, modulation_i = 1'h0, reset_pin_n_i = 1'h1;
  logic [1:0]  hs_ol = 2'h0, hs_cl = 2'h0, ls_ol = 2'h0, ls_cl = 2'h0;
  logic        hs_ot = 1'h0, ls_ot = 1'h0, shv = 1'h0, clk_en = 1'h1;
  logic [31:0] sw_rdata_o;
  logic        irq_o, hs1, hs2, ls1, ls2;
  logic [3:0]  q;
  int          n_errors = 0, checked = 0;
  wire  [3:0]  outs = {ls2, ls1, hs2, hs1};
  always #20 clk_sys_i = ~clk_sys_i;
  switch_link_if link ();
  switch_driver_host i_switch_driver_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .modulation_i(modulation_i),
    .reset_pin_n_i(reset_pin_n_i), .irq_o(irq_o), .link(link));
  switch_driver_control i_switch_driver_control (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en), .link(link), .hs_open_load_i(hs_ol), .hs_current_limit_i(hs_cl),
    .hs_over_temp_i(hs_ot), .ls_open_load_i(ls_ol), .ls_current_limit_i(ls_cl),
    .ls_over_temp_i(ls_ot), .supply_high_voltage_i(shv), .high_side_out_1_o(hs1),
    .high_side_out_2_o(hs2), .low_side_out_1_o(ls1), .low_side_out_2_o(ls2));
  switch_driver_assertions i_switch_driver_assertions (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .wr(link.wr), .rd(link.rd), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .modulation_input_pin(link.modulation_input_pin),
    .irq_n(link.irq_n), .reset_pin_n(link.reset_pin_n), .hs_over_temp_i(hs_ot),
    .ls_over_temp_i(ls_ot), .supply_high_voltage_i(shv), .high_side_out_1_o(hs1),
    .high_side_out_2_o(hs2), .low_side_out_1_o(ls1), .low_side_out_2_o(ls2));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic sw_op(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= w;
    sw_rd_i <= !w;
    @(posedge clk_sys_i);
    sw_wr_i <= 1'h0;
    sw_rd_i <= 1'h0;
  endtask
  // One link transfer; the controller is idle again three cycles after taking a read command, two after a write
  task automatic reg_op(input logic [3:0] a, input logic [3:0] d, input logic w,
                        output logic [3:0] r);
    sw_op(switch_driver_pkg::OFS_CMD, {23'h0, w, d, a}, 1'h1);
    repeat (5) @(posedge clk_sys_i);
    sw_op(switch_driver_pkg::OFS_DATA, 32'h0, 1'h0);
    #1 r = sw_rdata_o[3:0];
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    #1 chk({irq_o, outs}, 32'h0);
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h3, 1'h1, q);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h3, 1'h1, q);
    chk(outs, 32'hF);
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'hD, 1'h1, q);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'hE, 1'h1, q);
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk_sys_i) modulation_i <= m[0];
      repeat (2) @(posedge clk_sys_i);
      #1 chk(outs, {28'h0, m[0], 2'h0, m[0]});
    end
    // Clock enable low freezes the gated outputs against a pin change
    @(posedge clk_sys_i) {clk_en, modulation_i} <= 2'h1;
    repeat (2) @(posedge clk_sys_i);
    #1 chk(outs, 32'h0);
    @(posedge clk_sys_i) {clk_en, modulation_i} <= 2'h2;
    @(posedge clk_sys_i) {hs_ol, hs_cl, ls_ol, ls_cl} <= 8'h69;
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h0, 1'h0, q);
    chk(q, 32'h9);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h0, 1'h0, q);
    chk(q, 32'h6);
    reg_op(switch_driver_pkg::ADDR_IRQ, 4'h2, 1'h1, q);
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h3, 1'h1, q);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h3, 1'h1, q);
    @(posedge clk_sys_i) hs_ot <= 1'h1;
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h3, 1'h1, q);
    chk({irq_o, outs}, 32'h1C);
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h0, 1'h0, q);
    chk(q, 32'hF);
    @(posedge clk_sys_i) hs_ot <= 1'h0;
    reg_op(switch_driver_pkg::ADDR_IRQ, 4'h0, 1'h0, q);
    chk(q, 32'h2);
    chk({irq_o, outs}, 32'hC);
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h3, 1'h1, q);
    chk(outs, 32'hF);
    @(posedge clk_sys_i) ls_ot <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk({irq_o, outs}, 32'h3);
    @(posedge clk_sys_i) ls_ot <= 1'h0;
    reg_op(switch_driver_pkg::ADDR_IRQ, 4'h0, 1'h0, q);
    chk(q, 32'h1);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h3, 1'h1, q);
    chk(outs, 32'hF);
    reg_op(switch_driver_pkg::ADDR_MODE_CONTROL, 4'h8, 1'h1, q);
    @(posedge clk_sys_i) shv <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(outs, 32'h0);
    @(posedge clk_sys_i) shv <= 1'h0;
    reg_op(switch_driver_pkg::ADDR_HIGH_SIDE, 4'h3, 1'h1, q);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h3, 1'h1, q);
    chk(outs, 32'hF);
    reg_op(switch_driver_pkg::ADDR_IRQ, 4'h3, 1'h1, q);
    @(posedge clk_sys_i) {reset_pin_n_i, ls_ot} <= 2'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(irq_o, 32'h0);
    @(posedge clk_sys_i) {reset_pin_n_i, ls_ot} <= 2'h2;
    reg_op(switch_driver_pkg::ADDR_IRQ, 4'h0, 1'h0, q);
    reg_op(switch_driver_pkg::ADDR_LOW_SIDE, 4'h3, 1'h1, q);
    for (int k = 1; k < 3; k++) begin
      reg_op(switch_driver_pkg::ADDR_MODE_CONTROL, k[3:0], 1'h1, q);
      chk(outs, 32'h3);
    end
    @(posedge clk_sys_i) ls_ot <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(irq_o, 32'h1);
    sw_op(switch_driver_pkg::OFS_IRQ, 32'h0, 1'h0);
    #1 chk(sw_rdata_o, 32'h1);
    @(posedge clk_sys_i) ls_ot <= 1'h0;
    sw_op(switch_driver_pkg::OFS_CMD, {23'h0, 1'h0, 4'h0, switch_driver_pkg::ADDR_IRQ}, 1'h1);
    sw_op(switch_driver_pkg::OFS_STATUS, 32'h0, 1'h0);
    #1 chk(sw_rdata_o, 32'h10);
    repeat (3) @(posedge clk_sys_i);
    sw_op(switch_driver_pkg::OFS_DATA, 32'h0, 1'h0);
    #1 chk(sw_rdata_o, 32'h1);
    chk(irq_o, 32'h0);
    complete_run();
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
